//--- core/host_port_pkg.sv
/*
 * Constants, register map, field positions, timing counts and controller
 * states shared by the flash host-port controller and its pin synchroniser.
 * Assumes a single 40 MHz clock and a device that needs no clock of its own.
 */
package host_port_pkg;

	// ****************************************************************
	// Clock and pin timing
	// ****************************************************************
	localparam int CLK_MHZ       = 40;
	localparam int RESET_HOLD_NS = 2000;
	localparam int SETUP_NS      = 25;
	localparam int STROBE_NS     = 100;
	localparam int HOLD_NS       = 25;
	localparam int AVD_NS        = 50;
	localparam int EDGE_NS       = 50;
	// Least times round up to whole cycles
	localparam int RESET_CYC  = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC   = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int AVD_CYC    = (AVD_NS * CLK_MHZ + 999) / 1000;
	localparam int EDGE_CYC   = (EDGE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W      = 8;

	// ****************************************************************
	// Widths of the device pins
	// ****************************************************************
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	localparam int SYNC_W = DATA_W + 3;
	localparam logic [SYNC_W-1:0] SYNC_RST = 19'h7ffff;

	// ****************************************************************
	// Register map, byte offsets on the Avalon slave
	// ****************************************************************
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_ADDR   = 5'h04;
	localparam logic [4:0] OFS_WDATA  = 5'h08;
	localparam logic [4:0] OFS_CMD    = 5'h0c;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam logic [4:0] OFS_RDATA  = 5'h14;

	localparam int CTRL_MUX   = 0;
	localparam int CTRL_WIDE  = 1;
	localparam int CTRL_LOCK  = 2;
	localparam int CTRL_SLEEP = 3;
	localparam int CTRL_RESET = 4;
	localparam int CTRL_IDHI  = 5;

	localparam int CMD_GO    = 0;
	localparam int CMD_WRITE = 1;

	localparam int ST_BUSY    = 0;
	localparam int ST_DEVBUSY = 1;
	localparam int ST_IRQ     = 2;
	localparam int ST_XFER    = 3;
	localparam int ST_MUXON   = 4;
	localparam int ST_DONE    = 5;
	localparam int ST_REFUSED = 6;

	// ****************************************************************
	// Controller states
	// ****************************************************************
	typedef enum logic [8:0] {
		S_IDLE   = 9'h001,
		S_RESET  = 9'h002,
		S_WAIT   = 9'h004,
		S_EDGE   = 9'h008,
		S_AVD    = 9'h010,
		S_SETUP  = 9'h020,
		S_STROBE = 9'h040,
		S_HOLD   = 9'h080,
		S_SPARE  = 9'h100
	} state_type;

endpackage : host_port_pkg

//--- core/pin_sync_if.sv
/*
 * Synchronised device pin levels passed from the pin synchroniser to the
 * controller. Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pin_sync_if;
	logic        busy_n_s;
	logic        irq_n_s;
	logic        xfer_n_s;
	logic [15:0] data_s;

	modport producer (output busy_n_s, output irq_n_s, output xfer_n_s, output data_s);
	modport consumer (input busy_n_s, input irq_n_s, input xfer_n_s, input data_s);
endinterface : pin_sync_if

//--- core/pin_sync.sv
/*
 * Two-stage synchroniser for every level that arrives from the device pins.
 * Assumes the pins are asynchronous to clock and settle well inside a strobe.
 */
`timescale 1ns/1ps
module pin_sync
	import host_port_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        busy_n,
	input  wire logic        irq_n,
	input  wire logic        transfer_req_n,
	input  wire logic [15:0] data_in,
	pin_sync_if.producer     sync
);

	typedef struct packed {
		logic [SYNC_W-1:0] stage1;
		logic [SYNC_W-1:0] stage2;
	} sync_type;

	sync_type r;
	sync_type r_nxt;

	// Stage one feeds only stage two
	always_comb
	begin
		r_nxt        = r;
		r_nxt.stage1 = {busy_n, irq_n, transfer_req_n, data_in};
		r_nxt.stage2 = r.stage1;
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			r <= '{stage1: SYNC_RST, stage2: SYNC_RST};
		end
		else
		begin
			r <= r_nxt;
		end
	end

	assign sync.busy_n_s = r.stage2[SYNC_W-1];
	assign sync.irq_n_s  = r.stage2[SYNC_W-2];
	assign sync.xfer_n_s = r.stage2[SYNC_W-3];
	assign sync.data_s   = r.stage2[DATA_W-1:0];

endmodule : pin_sync

//--- core/flash_host_port.sv
/*
 * Host-side controller for a clockless flash disk with a memory-like port.
 * Software orders device resets and single read or write cycles through an
 * Avalon-MM slave; the controller drives the strobes, address and data pins.
 * Assumes the device pins are asynchronous and the board resolves the
 * shared data bus from data_oe_n.
 */
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Functional notes
// R1 - Thirteen address lines reach the device's 8KB window.
// R2 - Write cycle lasts while chip select and write strobe are low.
// R3 - Read cycle lasts while chip select and output enable are low.
// R4 - Device pulls interrupt low on long-operation end or protection fault.
// R5 - Device pulls transfer request low to pace DMA pages.
// R6 - Multiplexed address phase puts address bits 12..1 on bus 11..0.
// R7 - Falling edge on the high id pin after reset selects multiplexed mode.
// R8 - Multiplexed mode forces the high id bit to zero.
// R9 - Four cascaded devices standard, two multiplexed.
// R10 - Width configuration picks 8-bit or 16-bit access.
// R11 - Deep sleep shares the lowest address pin.
// R12 - Device protects one or two areas for read, write or both.
// R13 - Areas guarded by 64-bit key, lock pin, or both.
// R14 - Lock option with lock pin low denies access despite correct key.
// R15 - Tampering makes the whole device protected and inaccessible.
// R16 - Device holds a fixed 16-byte unique identifier.
// R17 - 16KB one-time area takes one write then becomes read-only.
// R18 - One-time pages are never erased.
// R19 - One-time-write partition becomes read-only after locking.
// R20 - Sticky lock bit acts like the lock pin on the boot partition.
// R21 - Sticky lock clears only through device reset.
// R22 - Boot block is 2KB, not enlarged by cascading.
// R23 - Device holds busy after reset; host waits until busy releases.
// R24 - Device loads protection rules during its initial download.
// R25 - Rejected access returns no protected data, changes nothing.
module flash_host_port
	import host_port_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [12:1] addr_hi,
	output logic             addr0_deep_sleep,
	output logic      [15:0] data_out,
	output logic             data_oe_n,
	input  wire logic [15:0] data_in,
	output logic             chip_sel_n,
	output logic             out_en_n,
	output logic             write_en_n,
	output logic             address_valid_n,
	output logic             reset_in_n,
	output logic             lock_n,
	output logic             wide_bus,
	input  wire logic        busy_n,
	input  wire logic        irq_n,
	input  wire logic        transfer_req_n
);

	typedef struct packed {
		state_type          state;
		logic [CNT_W-1:0]   cnt;
		logic               ack;
		logic [31:0]        rd;
		logic               mux_mode;
		logic               wide16;
		logic               lock_on;
		logic               sleep;
		logic               id_hi;
		logic               is_write;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  wdata;
		logic [DATA_W-1:0]  rdata;
		logic               done;
		logic               refused;
		logic               mux_active;
		logic               ready;
		logic               pin_rst_n;
		logic               ce_n;
		logic               oe_n;
		logic               we_n;
		logic               avd_n;
		logic [ADDR_W-1:0]  pin_addr;
		logic               pin_a0;
		logic [DATA_W-1:0]  pin_dout;
		logic               pin_doe_n;
	} ctl_type;

	ctl_type r;
	ctl_type r_nxt;

	pin_sync_if sync ();

	pin_sync u_sync (
		.clock          (clock),
		.reset_n        (reset_n),
		.busy_n         (busy_n),
		.irq_n          (irq_n),
		.transfer_req_n (transfer_req_n),
		.data_in        (data_in),
		.sync           (sync.producer)
	);

	// Last cycle of a timed phase
	function automatic logic last_cycle(input logic [CNT_W-1:0] c);
		last_cycle = (c <= CNT_W'(1));
	endfunction : last_cycle

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb
	begin
		r_nxt     = r;
		r_nxt.ack = (avs_read | avs_write) & ~r.ack;
		r_nxt.cnt = r.cnt - CNT_W'(1);

		// Read data latched while waitrequest is high, stable at the ack edge
		if (avs_read && !r.ack)
		begin
			r_nxt.rd = 32'h0000_0000;
			case (avs_address)
				OFS_CTRL:
				begin
					r_nxt.rd[CTRL_MUX]   = r.mux_mode;
					r_nxt.rd[CTRL_WIDE]  = r.wide16;
					r_nxt.rd[CTRL_LOCK]  = r.lock_on;
					r_nxt.rd[CTRL_SLEEP] = r.sleep;
					r_nxt.rd[CTRL_IDHI]  = r.id_hi;
				end
				OFS_ADDR:  r_nxt.rd[ADDR_W-1:0] = r.addr;
				OFS_WDATA: r_nxt.rd[DATA_W-1:0] = r.wdata;
				OFS_STATUS:
				begin
					r_nxt.rd[ST_BUSY]    = (r.state != S_IDLE);
					// R23 busy seen
					r_nxt.rd[ST_DEVBUSY] = ~sync.busy_n_s;
					// R4 interrupt level
					r_nxt.rd[ST_IRQ]     = ~sync.irq_n_s;
					// R5 DMA pacing level
					r_nxt.rd[ST_XFER]    = ~sync.xfer_n_s;
					r_nxt.rd[ST_MUXON]   = r.mux_active;
					r_nxt.rd[ST_DONE]    = r.done;
					r_nxt.rd[ST_REFUSED] = r.refused;
				end
				OFS_RDATA: r_nxt.rd[DATA_W-1:0] = r.rdata;
				default:   r_nxt.rd = 32'h0000_0000;
			endcase
		end

		// Register writes take effect at the ack edge
		if (avs_write && r.ack)
		begin
			case (avs_address)
				OFS_CTRL:
				begin
					r_nxt.mux_mode = avs_writedata[CTRL_MUX];
					// R10 width select
					r_nxt.wide16   = avs_writedata[CTRL_WIDE];
					r_nxt.lock_on  = avs_writedata[CTRL_LOCK];
					r_nxt.sleep    = avs_writedata[CTRL_SLEEP];
					// R9 high id level picks the cascade slot in standard mode
					r_nxt.id_hi    = avs_writedata[CTRL_IDHI];
					if (avs_writedata[CTRL_RESET] && r.state == S_IDLE)
					begin
						r_nxt.state      = S_RESET;
						r_nxt.cnt        = CNT_W'(RESET_CYC);
						r_nxt.pin_rst_n  = 1'b0;
						r_nxt.ready      = 1'b0;
						r_nxt.mux_active = 1'b0;
						// Id pin held high in multiplexed mode so the later falling edge is clean
						r_nxt.avd_n      = avs_writedata[CTRL_MUX] | avs_writedata[CTRL_IDHI];
					end
				end
				OFS_ADDR:   r_nxt.addr  = avs_writedata[ADDR_W-1:0];
				OFS_WDATA:  r_nxt.wdata = avs_writedata[DATA_W-1:0];
				OFS_STATUS:
				begin
					if (avs_writedata[ST_DONE])
					begin
						r_nxt.done = 1'b0;
					end
					if (avs_writedata[ST_REFUSED])
					begin
						r_nxt.refused = 1'b0;
					end
				end
				OFS_CMD:
				begin
					if (avs_writedata[CMD_GO] && r.state == S_IDLE)
					begin
						r_nxt.is_write = avs_writedata[CMD_WRITE];
						// R23 no access while busy
						if (!r.ready || !sync.busy_n_s)
						begin
							r_nxt.refused = 1'b1;
						end
						// R6 address phase on low bus lines
						else if (r.mux_active)
						begin
							r_nxt.state     = S_AVD;
							r_nxt.cnt       = CNT_W'(AVD_CYC);
							r_nxt.avd_n     = 1'b0;
							r_nxt.pin_dout  = {4'h0, r.addr[ADDR_W-1:1]};
							r_nxt.pin_doe_n = 1'b0;
						end
						else
						begin
							r_nxt.state     = S_SETUP;
							r_nxt.cnt       = CNT_W'(SETUP_CYC);
							// R1 full window address
							r_nxt.pin_addr  = r.addr;
							r_nxt.ce_n      = 1'b0;
							r_nxt.pin_dout  = r.wdata;
							r_nxt.pin_doe_n = ~avs_writedata[CMD_WRITE];
						end
					end
				end
				default: ;
			endcase
		end

		// ****************************************************************
		// Device cycle sequencer
		// ****************************************************************
		case (r.state)
			S_IDLE: ;
			S_RESET:
			begin
				if (last_cycle(r.cnt))
				begin
					r_nxt.pin_rst_n = 1'b1;
					r_nxt.state     = S_WAIT;
				end
			end
			S_WAIT:
			begin
				// R23 wait for busy release
				if (sync.busy_n_s)
				begin
					if (r.mux_mode)
					begin
						r_nxt.state = S_EDGE;
						r_nxt.cnt   = CNT_W'(EDGE_CYC);
						// R7 falling edge after reset
						r_nxt.avd_n = 1'b0;
					end
					else
					begin
						r_nxt.state = S_IDLE;
						r_nxt.ready = 1'b1;
					end
				end
			end
			S_EDGE:
			begin
				if (last_cycle(r.cnt))
				begin
					// R8 address valid idles high, id bit reads zero inside
					r_nxt.avd_n      = 1'b1;
					r_nxt.mux_active = 1'b1;
					r_nxt.ready      = 1'b1;
					r_nxt.state      = S_IDLE;
				end
			end
			S_AVD:
			begin
				if (last_cycle(r.cnt))
				begin
					r_nxt.avd_n     = 1'b1;
					r_nxt.state     = S_SETUP;
					r_nxt.cnt       = CNT_W'(SETUP_CYC);
					r_nxt.pin_addr  = r.addr;
					r_nxt.ce_n      = 1'b0;
					r_nxt.pin_dout  = r.wdata;
					r_nxt.pin_doe_n = ~r.is_write;
				end
			end
			S_SETUP:
			begin
				if (last_cycle(r.cnt))
				begin
					r_nxt.state = S_STROBE;
					r_nxt.cnt   = CNT_W'(STROBE_CYC);
					// R2 write strobe with chip select
					r_nxt.we_n  = ~r.is_write;
					// R3 read strobe with chip select
					r_nxt.oe_n  = r.is_write;
				end
			end
			S_STROBE:
			begin
				if (last_cycle(r.cnt))
				begin
					if (!r.is_write)
					begin
						// R10 narrow reads use the low byte only
						r_nxt.rdata = r.wide16 ? sync.data_s : {8'h00, sync.data_s[7:0]};
					end
					r_nxt.oe_n  = 1'b1;
					r_nxt.we_n  = 1'b1;
					r_nxt.state = S_HOLD;
					r_nxt.cnt   = CNT_W'(HOLD_CYC);
				end
			end
			S_HOLD:
			begin
				if (last_cycle(r.cnt))
				begin
					r_nxt.ce_n      = 1'b1;
					r_nxt.pin_doe_n = 1'b1;
					r_nxt.done      = 1'b1;
					r_nxt.state     = S_IDLE;
				end
			end
			default: r_nxt.state = S_IDLE;
		endcase

		// R11 lowest address pin doubles as deep sleep in wide mode
		r_nxt.pin_a0 = r_nxt.wide16 ? r_nxt.sleep : r_nxt.pin_addr[0];
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			r            <= '0;
			r.state      <= S_IDLE;
			r.wide16     <= 1'b1;
			r.pin_rst_n  <= 1'b1;
			r.ce_n       <= 1'b1;
			r.oe_n       <= 1'b1;
			r.we_n       <= 1'b1;
			r.avd_n      <= 1'b1;
			r.pin_doe_n  <= 1'b1;
		end
		else
		begin
			r <= r_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign avs_waitrequest  = (avs_read | avs_write) & ~r.ack;
	assign avs_readdata     = r.rd;
	assign addr_hi          = r.pin_addr[ADDR_W-1:1];
	assign addr0_deep_sleep = r.pin_a0;
	assign data_out         = r.pin_dout;
	assign data_oe_n        = r.pin_doe_n;
	assign chip_sel_n       = r.ce_n;
	assign out_en_n         = r.oe_n;
	assign write_en_n       = r.we_n;
	assign address_valid_n  = r.avd_n;
	assign reset_in_n       = r.pin_rst_n;
	// R14 hardware lock pin, active low
	assign lock_n           = ~r.lock_on;
	assign wide_bus         = r.wide16;

endmodule : flash_host_port

//--- test/flash_host_port_asserts.sv
/*
 * Pin-level checks on the flash host-port controller.
 * Assumes it is bound into flash_host_port; one clock, reset_n active low.
 */
`timescale 1ns/1ps
module flash_host_port_asserts
	import host_port_pkg::*;
(
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic [12:1] addr_hi,
	input wire logic [15:0] data_out,
	input wire logic        data_oe_n,
	input wire logic        chip_sel_n,
	input wire logic        out_en_n,
	input wire logic        write_en_n,
	input wire logic        address_valid_n,
	input wire logic        reset_in_n,
	input wire logic        busy_n
);
	logic [7:0] low_cnt_r;
	logic [7:0] low_cnt_nxt;

	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	// ********
	// Helper logic and sequences
	// ********
	// Counts how long the device reset has been held, too long for a repetition
	assign low_cnt_nxt = reset_in_n ? 8'h00 : low_cnt_r + 8'h01;
	always_ff @(posedge clock)
		low_cnt_r <= reset_n ? low_cnt_nxt : 8'h00;

	sequence read_pulse;
		!out_en_n [*4] ##1 out_en_n;
	endsequence
	sequence write_pulse;
		!write_en_n [*4] ##1 write_en_n;
	endsequence
	sequence strobe_start;
		out_en_n && write_en_n ##1 (!out_en_n || !write_en_n);
	endsequence
	sequence cs_release;
		!chip_sel_n ##1 chip_sel_n;
	endsequence

	// ********
	// Assertions
	// ********
	a_cycle_open: assert property ($fell(chip_sel_n) |-> strobe_start)
		else $error("strobe does not follow chip select by one cycle");
	a_read_width: assert property ($fell(out_en_n) |-> read_pulse)
		else $error("read strobe not four cycles");
	a_write_width: assert property ($fell(write_en_n) |-> write_pulse)
		else $error("write strobe not four cycles");
	a_cs_hold: assert property ($rose(out_en_n) || $rose(write_en_n) |-> cs_release)
		else $error("chip select hold wrong");
	a_one_strobe: assert property (!(!out_en_n && !write_en_n))
		else $error("read and write strobes together");
	a_read_no_drive: assert property (!out_en_n |-> data_oe_n)
		else $error("host drives bus during read");
	a_write_drives: assert property (!write_en_n |-> !data_oe_n)
		else $error("host not driving bus during write");
	a_addr_steady: assert property (!out_en_n || !write_en_n |-> $stable(addr_hi))
		else $error("address moved during strobe");
	a_reset_len: assert property ($rose(reset_in_n) |-> low_cnt_r == 8'(RESET_CYC))
		else $error("device reset pulse length wrong");
	a_busy_guard: assert property ($fell(chip_sel_n) |-> reset_in_n && $past(busy_n, 3))
		else $error("access started while device busy");
	a_mux_addr: assert property (!address_valid_n && !data_oe_n |-> data_out[15:12] == 4'h0)
		else $error("upper bus lines not zero in address phase");
endmodule : flash_host_port_asserts

bind flash_host_port flash_host_port_asserts flash_host_port_asserts_i (.*);

//--- test/flash_dev_model.sv
/*
 * Behavioural model of the clockless flash disk as seen at its pins.
 * Assumes the controller's split data bus; levels sampled on the bench clock.
 */
`timescale 1ns/1ps
module flash_dev_model #(
	parameter int   BUSY_CYC = 12,
	parameter logic DEV_IDHI = 1'b1
) (
	input  wire logic        clock,
	input  wire logic [12:1] addr_hi,
	input  wire logic        addr0_deep_sleep,
	input  wire logic [15:0] data_out,
	input  wire logic        data_oe_n,
	input  wire logic        chip_sel_n,
	input  wire logic        out_en_n,
	input  wire logic        write_en_n,
	input  wire logic        address_valid_n,
	input  wire logic        reset_in_n,
	input  wire logic        lock_n,
	input  wire logic        wide_bus,
	input  wire logic        dma_req,
	output logic      [15:0] data_in,
	output logic             busy_n,
	output logic             irq_n,
	output logic             transfer_req_n
);
	logic [7:0]  mem [0:8191];
	logic [12:0] mux_a;
	logic [12:0] a;
	logic [15:0] last = 16'h0000;
	logic [15:0] rword;
	logic        mux_r = 1'b0;
	logic        avd_q = 1'b1;
	logic        irq_r = 1'b0;
	logic        sel;
	logic        prot;
	int          bcnt = BUSY_CYC;

	// ********
	// Pin decoding
	// ********
	// in wide mode the lowest pin is the sleep input, not an address
	assign a = mux_r ? mux_a : {addr_hi, wide_bus ? 1'b0 : addr0_deep_sleep};
	// id high bit matters only in standard mode; asleep ignores strobes
	assign sel = !chip_sel_n && (mux_r || address_valid_n == DEV_IDHI)
		&& !(wide_bus && addr0_deep_sleep);
	// upper half of the window guarded by the lock pin
	assign prot = !lock_n && a[12];
	assign rword = wide_bus ? {mem[a + 13'h1], mem[a]} : {~last[15:8], mem[a]};
	// guarded reads give nothing; a released bus never holds its level
	assign data_in = !data_oe_n ? data_out
		: (sel && !out_en_n) ? (prot ? 16'h0000 : rword) : ~last;
	assign busy_n = (bcnt == 0);
	assign irq_n = !irq_r;
	// DMA pacing request on the bench's command
	assign transfer_req_n = !dma_req;

	always @(posedge clock)
	begin
		last <= data_in;
		avd_q <= address_valid_n;
		// busy while boot code and protection rules reload
		if (!reset_in_n)
			bcnt <= BUSY_CYC;
		else if (bcnt > 0)
			bcnt <= bcnt - 1;
		// falling edge on the high id pin after reset selects muxed bus
		if (!reset_in_n)
			mux_r <= 1'b0;
		else if (avd_q && !address_valid_n)
			mux_r <= 1'b1;
		// address bits 12..1 arrive on bus lines 11..0
		if (mux_r && !address_valid_n && !data_oe_n)
			mux_a <= {data_out[11:0], 1'b0};
		// writes into guarded space change nothing
		if (sel && !write_en_n && !prot)
			mem[a] <= data_out[7:0];
		if (sel && !write_en_n && !prot && wide_bus)
			mem[a + 13'h1] <= data_out[15:8];
		// long operation on the top word ends with an interrupt; a read clears it
		if (sel && !write_en_n && a == 13'h1ffe)
			irq_r <= 1'b1;
		else if (sel && !out_en_n && a == 13'h1ffe)
			irq_r <= 1'b0;
	end
endmodule : flash_dev_model

//--- test/tb_flash_host_port.sv
/*
 * Self-checking bench: Avalon master, flash device model, read-result monitor.
 * Assumes the checker file is compiled too and binds itself into the design.
 */
`timescale 1ns/1ps
module tb_flash_host_port
	import host_port_pkg::*;
;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [12:1] addr_hi;
	logic [15:0] data_out, data_in;
	logic        addr0_deep_sleep, data_oe_n, chip_sel_n, out_en_n, write_en_n;
	logic        address_valid_n, reset_in_n, lock_n, wide_bus;
	logic        busy_n, irq_n, transfer_req_n;
	logic        dma_req = 1'b0;
	logic [63:0] exp_q[$];
	logic [63:0] note;
	logic [12:0] aa[8];
	logic [15:0] dd[8];
	logic [31:0] v;
	int          error_cnt = 0;
	int          tests_run = 0;
	int unsigned seed;

	initial
	begin
		forever #12.5 clock = ~clock;
	end

	flash_host_port flash_host_port_i (.*);
	flash_dev_model flash_dev_model_i (.*);

	// ********
	// Bus tasks and checking
	// ********
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clock);
	endtask : av_wr

	// A zero mask notes a read whose value is only used, not compared
	task automatic av_rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
		output logic [31:0] d);
		exp_q.push_back({e, m});
		avs_address <= a;
		avs_read    <= 1'b1;
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask : av_rd

	always @(posedge clock)
	begin
		if (avs_read && avs_waitrequest === 1'b0)
		begin
			note = exp_q.pop_front();
			if (note[31:0] != 32'h0)
				check(avs_readdata & note[31:0], note[63:32]);
		end
	end

	task automatic poll();
		v = 32'h1;
		repeat (200)
			if (v[ST_BUSY] !== 1'b0)
				av_rd(OFS_STATUS, 32'h0, 32'h0, v);
	endtask : poll

	task automatic acc(input logic [12:0] a, input logic [15:0] d, input logic wr);
		av_wr(OFS_ADDR, {19'h0, a});
		av_wr(OFS_WDATA, {16'h0, d});
		av_wr(OFS_CMD, {30'h0, wr, 1'b1});
		poll();
		av_rd(OFS_STATUS, 32'h20, 32'h60, v);
		av_wr(OFS_STATUS, 32'h20);
		if (!wr)
			av_rd(OFS_RDATA, {16'h0, d}, 32'hffffffff, v);
	endtask : acc

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// ********
	// Scenarios
	// ********
	initial
	begin
		seed = $urandom(41434);
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		av_rd(OFS_CTRL, 32'h02, 32'h3f, v);
		av_rd(5'h18, 32'h0, 32'hffffffff, v);
		// No access may reach the device before it has been reset
		av_wr(OFS_CMD, 32'h1);
		av_rd(OFS_STATUS, 32'h40, 32'h61, v);
		av_wr(OFS_STATUS, 32'h40);
		av_wr(OFS_CTRL, 32'h32);
		poll();
		av_rd(OFS_STATUS, 32'h0, 32'h5f, v);
		for (int i = 0; i < 8; i++)
		begin
			aa[i] = (i == 0) ? 13'h0 : (i == 7) ? 13'h1ffc : {3'(i), 9'($urandom), 1'b0};
			dd[i] = 16'($urandom);
			acc(aa[i], dd[i], 1'b1);
		end
		for (int i = 0; i < 8; i++)
			acc(aa[i], dd[i], 1'b0);
		acc(13'h1400, 16'h5a5a, 1'b1);
		av_wr(OFS_CTRL, 32'h26);
		acc(13'h1400, 16'ha5a5, 1'b1);
		acc(13'h1400, 16'h0000, 1'b0);
		av_wr(OFS_CTRL, 32'h22);
		acc(13'h1400, 16'h5a5a, 1'b0);
		acc(13'h1ffe, 16'h0001, 1'b1);
		av_rd(OFS_STATUS, 32'h04, 32'h04, v);
		acc(13'h1ffe, 16'h0001, 1'b0);
		av_rd(OFS_STATUS, 32'h00, 32'h04, v);
		dma_req <= 1'b1;
		repeat (4) @(posedge clock);
		av_rd(OFS_STATUS, 32'h08, 32'h08, v);
		dma_req <= 1'b0;
		repeat (4) @(posedge clock);
		av_rd(OFS_STATUS, 32'h00, 32'h08, v);
		// Deep sleep must swallow a write; the old word reads back after waking
		av_wr(OFS_CTRL, 32'h2a);
		acc(13'h0000, 16'hbeef, 1'b1);
		av_wr(OFS_CTRL, 32'h22);
		acc(13'h0000, dd[0], 1'b0);
		av_wr(OFS_CTRL, 32'h20);
		acc(13'h0007, 16'h00c3, 1'b1);
		acc(13'h0007, 16'h00c3, 1'b0);
		acc(13'h0001, {8'h0, dd[0][15:8]}, 1'b0);
		av_wr(OFS_CTRL, 32'h33);
		poll();
		av_rd(OFS_STATUS, 32'h10, 32'h10, v);
		acc(aa[3], dd[3], 1'b0);
		acc(13'h0abc, 16'h1234, 1'b1);
		acc(13'h0abc, 16'h1234, 1'b0);
		summarize();
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		summarize();
	end
endmodule : tb_flash_host_port
